// File: testbench/dmfc_checker.sv
// assertion checker on the ports of the drive configuration block
`timescale 1ns/100ps
module dmfc_checker (
	input wire        clock_i,          // clock
	input wire        nrst_i,           // reset, active low
	input wire        od_req_i,         // access strobe
	input wire        od_wr_i,          // write
	input wire [15:0] od_index_i,       // index
	input wire [7:0]  od_sub_i,         // subindex
	input wire [31:0] od_wdata_i,       // write data
	input wire        od_ack_o,         // answer
	input wire        od_err_o,         // refused
	input wire [31:0] od_rdata_o,       // read data
	input wire        op_enabled_i,     // operation enabled
	input wire        torque_mode_i,    // torque mode
	input wire        reboot_o,         // reboot pulse
	input wire        windings_short_o, // short windings
	input wire        closed_loop_o,    // closed loop
	input wire        torque_only_o,    // torque alone
	input wire        vel_superimp_o,   // velocity superimposed
	input wire [7:0]  pos_src_o         // position source
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	wire wr_boot = od_req_i && od_wr_i && od_index_i == 16'h2800 && od_sub_i == 8'h03;
	wire rd_cnt  = od_req_i && !od_wr_i && od_index_i == 16'h3203 && od_sub_i == 8'h00;
	property p_ack; od_req_i |=> od_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("access not answered");
	property p_quiet; !od_req_i |=> !od_ack_o && !od_err_o && od_rdata_o == 32'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without access");
	property p_cnt; rd_cnt |=> od_rdata_o == 32'h3 && !od_err_o; endproperty
	a_cnt: assert property (p_cnt) else $error("entry count wrong");
	property p_map_ro; od_req_i && od_wr_i && od_index_i == 16'h3204 |=> od_err_o; endproperty
	a_map_ro: assert property (p_map_ro) else $error("mapping write accepted");
	property p_wind; wr_boot |=> ##1 windings_short_o != $past(od_wdata_i[0], 2); endproperty
	a_wind: assert property (p_wind) else $error("winding short wrong");
	property p_reboot; reboot_o |=> !reboot_o; endproperty
	a_reboot: assert property (p_reboot) else $error("reboot pulse too long");
	property p_off_open; !op_enabled_i |-> ##2 !closed_loop_o; endproperty
	a_off_open: assert property (p_off_open) else $error("closed loop while disabled");
	property p_torque;
		$past(nrst_i) |-> (torque_only_o | vel_superimp_o) == $past(torque_mode_i)
			&& !(torque_only_o && vel_superimp_o);
	endproperty
	a_torque: assert property (p_torque) else $error("torque control wrong");
	property p_src; pos_src_o >= 8'h01 && pos_src_o <= 8'h03; endproperty
	a_src: assert property (p_src) else $error("source out of range");
	property p_fb_hold;
		$past(op_enabled_i, 2) && $past(op_enabled_i, 3) |-> $stable(pos_src_o);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("selection changed in operation");
endmodule // dmfc_checker

bind dmfc_top dmfc_checker u_chk (
	.clock_i(clock_i), .nrst_i(nrst_i), .od_req_i(od_req_i), .od_wr_i(od_wr_i),
	.od_index_i(od_index_i), .od_sub_i(od_sub_i), .od_wdata_i(od_wdata_i),
	.od_ack_o(od_ack_o), .od_err_o(od_err_o), .od_rdata_o(od_rdata_o),
	.op_enabled_i(op_enabled_i), .torque_mode_i(torque_mode_i), .reboot_o(reboot_o),
	.windings_short_o(windings_short_o), .closed_loop_o(closed_loop_o),
	.torque_only_o(torque_only_o), .vel_superimp_o(vel_superimp_o), .pos_src_o(pos_src_o)
);

// File: testbench/dmfc_master.sv
// fieldbus master model issuing object accesses
`timescale 1ns/100ps
module dmfc_master (
	input  wire        clock_i, // clock
	output reg         req_o,   // strobe
	output reg         wr_o,    // write
	output reg  [15:0] idx_o,   // index
	output reg  [7:0]  sub_o,   // subindex
	output reg  [31:0] wd_o     // write data
);
	initial {req_o, wr_o, idx_o, sub_o, wd_o} = 58'h0;
	// fields inverted after the strobe so stale values never pass for valid ones
	task xfer(input w, input [15:0] x, input [7:0] s, input [31:0] d);
	begin
		@(negedge clock_i);
		{req_o, wr_o, idx_o, sub_o, wd_o} = {1'b1, w, x, s, d};
		@(negedge clock_i);
		{req_o, wr_o, idx_o, sub_o, wd_o} = {1'b0, ~w, ~x, ~s, ~d};
	end
	endtask
endmodule // dmfc_master

// File: testbench/drive_mode_feedback_config_test.sv
// self-checking bench for the drive configuration block
`timescale 1ns/100ps
module drive_mode_feedback_config_test;
	localparam MS = 4;
	reg         clock_i, nrst_i, op, tq, hx, ix, ad;
	wire        req, wr, ack, err, rb, wsh, cl, al, vs, bk, cr, tqo, vsp, bl, sl;
	wire [15:0] idx;
	wire [7:0]  sub, ps, vl, cm;
	wire [31:0] wd, rd;
	reg  [32:0] exp_q[$];
	integer     n_fail, checks_done, sd, i, k;
	reg  [31:0] r;
	dmfc_master m (.clock_i(clock_i), .req_o(req), .wr_o(wr), .idx_o(idx), .sub_o(sub), .wd_o(wd));
	dmfc_top #(.MS_CYCLES(MS)) DUT (
		.clock_i(clock_i), .nrst_i(nrst_i), .od_req_i(req), .od_wr_i(wr), .od_index_i(idx),
		.od_sub_i(sub), .od_wdata_i(wd), .od_ack_o(ack), .od_err_o(err), .od_rdata_o(rd),
		.op_enabled_i(op), .torque_mode_i(tq), .enc_has_index_i(hx), .enc_index_i(ix),
		.align_done_i(ad), .reboot_o(rb), .windings_short_o(wsh), .closed_loop_o(cl),
		.align_active_o(al), .speed_sim_o(vs), .brake_auto_o(bk), .cur_red_o(cr),
		.torque_only_o(tqo), .vel_superimp_o(vsp), .brushless_o(bl), .slow_mode_o(sl),
		.pos_src_o(ps), .vel_src_o(vl), .com_src_o(cm));
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	task fail(input [8*20:1] s);
	begin
		n_fail++;
		$display("[FAIL] %0t %0s", $time, s);
	end
	endtask
	task stop_test;
	begin
		if (exp_q.size() != 0) fail("answers missing");
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task chk(input [31:0] g, input [31:0] e);
	begin
		checks_done++;
		if (g !== e) fail("output mismatch");
	end
	endtask
	task chk_bus(input [32:0] e, input [32:0] g);
	begin
		checks_done++;
		if (g !== e) fail("answer mismatch");
	end
	endtask
	task need(input b, input [8*20:1] s);
	begin
		checks_done++;
		if (b !== 1'b1) begin
			fail(s);
			stop_test;
		end
	end
	endtask
	task tk(input integer c);
		repeat (c) @(negedge clock_i);
	endtask
	task acc(input w, input [15:0] x, input [7:0] s, input [31:0] d, input e, input [31:0] q);
	begin
		exp_q.push_back({e, q});
		m.xfer(w, x, s, d);
	end
	endtask
	task wait_rb(input integer lim, output integer n);
		for (n = 0; n < lim && rb !== 1'b1; n++) tk(1);
	endtask
	always @(negedge clock_i) if (ack === 1'b1) begin
		if (exp_q.size() == 0) fail("stray answer");
		else chk_bus(exp_q.pop_front(), {err, rd});
	end
	initial begin
		{nrst_i, op, tq, hx, ix, ad} = 6'h0;
		n_fail = 0;
		checks_done = 0;
		sd = 32'h795E8129;
		tk(16);
		nrst_i = 1;
		chk({wsh, cl, ps, vl, cm}, {1'b1, 1'b0, 8'h01, 8'h01, 8'h01});
		for (i = 0; i < 4; i++) begin
			acc(0, 16'h2800, i[7:0], 0, 0, i ? 0 : 3);
			acc(0, 16'h3203, i[7:0], 0, 0, i ? 0 : 3);
			acc(0, 16'h3204, i[7:0], 0, 0, i ? 16'h3370 + 16 * i : 3);
		end
		acc(1, 16'h3204, 1, 0, 1, 0);
		acc(1, 16'h3203, 0, 5, 1, 0);
		acc(0, 16'h3202, 1, 0, 1, 0);
		acc(0, 16'h1234, 0, 0, 1, 0);
		$display("reset values and refusals done");
		for (i = 0; i < 6; i++) begin
			r = $random(sd) & 32'hFFFFFF7E;
			tq = r[8];
			acc(1, 16'h3202, 0, r, 0, 0);
			acc(0, 16'h3202, 0, 0, 0, {24'h0, r[7:0]});
			tk(2);
			chk({vs, bk, bl, cr}, {r[1], r[2], r[6], r[3]});
			chk({tqo, vsp}, {tq & r[5], tq & ~r[5]});
		end
		for (i = 0; i < 2; i++) begin
			r = $random(sd) & 32'hFFFFFFFE | i;
			acc(1, 16'h2800, 3, r, 0, 0);
			acc(0, 16'h2800, 3, 0, 0, r);
			tk(2);
			chk(wsh, !i);
		end
		$display("submode and boot config done");
		acc(1, 16'h2800, 1, 32'h746F6F63, 0, 0);
		wait_rb(20, k);
		chk(k, 20);
		acc(1, 16'h2800, 1, 32'h746F6F62, 0, 0);
		wait_rb(20, k);
		need(k < 20, "reboot missing");
		chk(k, 1);
		acc(1, 16'h2800, 2, 2, 0, 0);
		acc(1, 16'h2800, 1, 32'h746F6F62, 0, 0);
		wait_rb(40, k);
		need(k >= 2 * MS && k <= 4 + 2 * (MS + 1), "reboot delay");
		$display("reboot done");
		acc(1, 16'h3203, 1, 7, 0, 0);
		acc(1, 16'h3203, 2, 2, 0, 0);
		acc(1, 16'h3203, 3, 32'hFFFFFF05, 0, 0);
		acc(0, 16'h3203, 3, 0, 0, 5);
		op = 1;
		tk(3);
		chk({ps, vl, cm}, {8'h3, 8'h2, 8'h1});
		acc(1, 16'h3203, 2, 7, 0, 0);
		tk(3);
		chk({ps, vl, cm}, {8'h3, 8'h2, 8'h1});
		op = 0;
		tk(1);
		op = 1;
		tk(3);
		chk({ps, vl, cm}, {8'h2, 8'h2, 8'h1});
		op = 0;
		hx = 1;
		acc(1, 16'h3202, 0, 32'h19, 0, 0);
		tk(2);
		op = 1;
		tk(3);
		need(al, "no alignment");
		ad = 1;
		tk(1);
		ad = 0;
		for (k = 0; k < 10 && cl !== 1'b1; k++) tk(1);
		need(cl, "no closed loop");
		chk({ps, vl, cm, cr}, {8'h2, 8'h2, 8'h2, 1'b0});
		acc(1, 16'h3202, 0, 32'h99, 0, 0);
		tk(2);
		chk(sl, 1);
		acc(1, 16'h3202, 0, 32'h98, 0, 0);
		tk(3);
		need(cl, "loop changed");
		op = 0;
		tk(3);
		chk({cl, sl}, 0);
		acc(1, 16'h3202, 0, 32'h01, 0, 0);
		tk(2);
		op = 1;
		tk(6);
		chk({cl, al}, 0);
		ix = 1;
		tk(1);
		ix = 0;
		for (k = 0; k < 10 && cl !== 1'b1; k++) tk(1);
		need(cl, "index ignored");
		op = 0;
		hx = 0;
		tk(3);
		op = 1;
		tk(3);
		need(al, "no forced alignment");
		op = 0;
		tk(3);
		$display("loop and feedback done");
		stop_test;
	end
endmodule // drive_mode_feedback_config_test

// File: verilog/dmfc_fb_search.v
// priority search of feedback sources for position, velocity and commutation
`timescale 1ns/100ps
`include "dmfc_regs.vh"
module dmfc_fb_search #(
	parameter NUM_FB = 3
) (
	input  wire [NUM_FB*8-1:0] masks_i,   // per-sensor masks, sensor 1 in low byte
	output reg  [7:0]          pos_src_o, // sensor number for position
	output reg  [7:0]          vel_src_o, // sensor number for velocity
	output reg  [7:0]          com_src_o  // sensor number for commutation
);
	genvar    f;

	generate
		for (f = 0; f < 3; f = f + 1) begin : g_func
			// per-function result and loop index keep each process the only driver
			reg [7:0] hit;
			integer   s;
			always @* begin
				// sensorless is the fallback when no other sensor claims the role
				hit = 8'h01;
				// descending walk so the lowest matching sensor wins
				for (s = NUM_FB - 1; s >= 1; s = s - 1) begin
					if (masks_i[s*8 + f])
						hit = s[7:0] + 8'h01;
				end
			end
		end
	endgenerate

	always @* begin
		pos_src_o = g_func[`DMFC_FB_POS].hit;
		vel_src_o = g_func[`DMFC_FB_VEL].hit;
		com_src_o = g_func[`DMFC_FB_COM].hit;
	end
endmodule // dmfc_fb_search

// File: verilog/dmfc_regs.vh
// object map, field positions, reset values and timing counts of the drive configuration block
`ifndef DMFC_REGS_VH
`define DMFC_REGS_VH

`define DMFC_IDX_BOOT        16'h2800
`define DMFC_IDX_SUBMODE     16'h3202
`define DMFC_IDX_FB_SELECT   16'h3203
`define DMFC_IDX_FB_MAP      16'h3204

`define DMFC_SUB_COUNT       8'h00
`define DMFC_SUB_REBOOT_CMD  8'h01
`define DMFC_SUB_REBOOT_DLY  8'h02
`define DMFC_SUB_BOOT_HW     8'h03

`define DMFC_BOOT_COUNT      8'h03
`define DMFC_FB_COUNT        8'h03
`define DMFC_REBOOT_MAGIC    32'h746F6F62
`define DMFC_WORD_RESET      32'h00000000
`define DMFC_SEL_RESET       8'h00
`define DMFC_MAP_FIRST       16'h3380
`define DMFC_MAP_SECOND      16'h3390
`define DMFC_MAP_THIRD       16'h33A0

`define DMFC_BOOT_NO_SHORT   0

`define DMFC_SM_LOOP         0
`define DMFC_SM_SPEED_SIM    1
`define DMFC_SM_BRAKE        2
`define DMFC_SM_CUR_RED      3
`define DMFC_SM_AUTO_ALIGN   4
`define DMFC_SM_TORQUE       5
`define DMFC_SM_BRUSHLESS    6
`define DMFC_SM_SLOW         7
`define DMFC_SM_USED_MASK    32'h000000FF

`define DMFC_FB_POS          0
`define DMFC_FB_VEL          1
`define DMFC_FB_COM          2

`define DMFC_CLK_MHZ         100
`define DMFC_MS_PER_TICK     1
`define DMFC_MS_CYCLES       (`DMFC_MS_PER_TICK * `DMFC_CLK_MHZ * 1000)

`endif

// File: verilog/dmfc_top.v
// drive submode, reboot, boot loader and feedback selection configuration
// Contract
// - writing the magic word to the reboot command triggers a reboot, nothing else does
// - the reboot fires after the number of milliseconds in the delay entry
// - boot config bit 0 set keeps windings unshorted, clear shorts them
// - submode bit 0 picks open loop at zero, closed loop at one
// - loop mode never changes while operation is enabled
// - speed simulation bit realises speed modes by ramped position changes
// - brake bit enables automatic brake control
// - current reduction bit reduces current during open loop only
// - encoder without index forces auto alignment on entry to operation enabled with closed loop selected
// - torque bit in torque modes runs torque controller alone, else velocity superimposed
// - motor type bit marks a brushless DC motor
// - slow bit activates slow speed mode, only with closed loop active
// - feedback selection writes take effect on next entry to operation enabled
// - selection masks: bit 0 position, bit 1 velocity, bit 2 commutation
// - subindex 1 always is the sensorless feedback, rest in sensor order
// - search from sensor 2 upward, first matching sensor wins
// - open loop ignores commutation bit, position and velocity still select display
// - mapping table reports configuring object indices 3380, 3390, 33A0
// - entry counts of both feedback tables read three
// - reboot, delay and boot config are 32-bit, reset zero, count three
`timescale 1ns/100ps
`include "dmfc_regs.vh"
module dmfc_top #(
	parameter MS_CYCLES = `DMFC_MS_CYCLES // cycles in one millisecond
) (
	input  wire        clock_i,          // 100 MHz clock
	input  wire        nrst_i,           // async reset, active low
	input  wire        od_req_i,         // object access strobe
	input  wire        od_wr_i,          // 1 write, 0 read
	input  wire [15:0] od_index_i,       // object index
	input  wire [7:0]  od_sub_i,         // subindex
	input  wire [31:0] od_wdata_i,       // write data
	output reg         od_ack_o,         // access answered
	output reg         od_err_o,         // access refused
	output reg  [31:0] od_rdata_o,       // read data
	input  wire        op_enabled_i,     // drive in operation enabled
	input  wire        torque_mode_i,    // profile or cyclic torque mode active
	input  wire        enc_has_index_i,  // commutation encoder provides an index
	input  wire        enc_index_i,      // encoder index pin
	input  wire        align_done_i,     // open loop alignment finished
	output reg         reboot_o,         // firmware reboot pulse
	output reg         windings_short_o, // short windings in boot loader
	output reg         closed_loop_o,    // commutating in closed loop
	output reg         align_active_o,   // open loop alignment running
	output reg         speed_sim_o,      // speed via position ramp
	output reg         brake_auto_o,     // automatic brake control
	output reg         cur_red_o,        // current reduction active
	output reg         torque_only_o,    // torque controller alone
	output reg         vel_superimp_o,   // velocity controller superimposed
	output reg         brushless_o,      // brushless DC motor
	output reg         slow_mode_o,      // slow speed mode active
	output reg  [7:0]  pos_src_o,        // position feedback sensor
	output reg  [7:0]  vel_src_o,        // velocity feedback sensor
	output reg  [7:0]  com_src_o         // commutation feedback sensor
);
	localparam ST_OPEN   = 3'b001;
	localparam ST_ALIGN  = 3'b010;
	localparam ST_CLOSED = 3'b100;

	reg [31:0] reboot_cmd;
	reg [31:0] reboot_dly;
	reg [31:0] boot_hw;
	reg [31:0] submode;
	reg [7:0]  sel_first;
	reg [7:0]  sel_second;
	reg [7:0]  sel_third;
	reg [23:0] sel_applied;
	reg        loop_applied;
	reg        op_en_q;
	reg        idx_meta;
	reg        idx_sync;
	reg [2:0]  state;
	reg [2:0]  next_state;
	reg        reboot_pend;
	reg [31:0] ms_left;
	reg [31:0] tick_cnt;
	reg [31:0] next_rdata;
	reg        next_err;

	wire       wr_ok;
	wire       op_rise;
	wire       ms_tick;
	wire [7:0] pos_sel;
	wire [7:0] vel_sel;
	wire [7:0] com_sel;

	assign op_rise = op_enabled_i & ~op_en_q;
	assign wr_ok   = od_req_i & od_wr_i & ~next_err;
	assign ms_tick = (tick_cnt == MS_CYCLES - 1);

	// object decode: reads return data, writes to read-only or unknown entries are refused
	always @* begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		case (od_index_i)
		`DMFC_IDX_BOOT: begin
			case (od_sub_i)
			`DMFC_SUB_COUNT: begin
				next_rdata = {24'h000000, `DMFC_BOOT_COUNT};
				next_err   = od_wr_i;
			end
			`DMFC_SUB_REBOOT_CMD: next_rdata = reboot_cmd;
			`DMFC_SUB_REBOOT_DLY: next_rdata = reboot_dly;
			`DMFC_SUB_BOOT_HW:    next_rdata = boot_hw;
			default:              next_err   = 1'b1;
			endcase
		end
		`DMFC_IDX_SUBMODE: begin
			if (od_sub_i == `DMFC_SUB_COUNT)
				next_rdata = submode;
			else
				next_err = 1'b1;
		end
		`DMFC_IDX_FB_SELECT: begin
			case (od_sub_i)
			8'h00: begin
				next_rdata = {24'h000000, `DMFC_FB_COUNT};
				next_err   = od_wr_i;
			end
			8'h01:   next_rdata = {24'h000000, sel_first};
			8'h02:   next_rdata = {24'h000000, sel_second};
			8'h03:   next_rdata = {24'h000000, sel_third};
			default: next_err   = 1'b1;
			endcase
		end
		`DMFC_IDX_FB_MAP: begin
			next_err = od_wr_i;
			case (od_sub_i)
			8'h00:   next_rdata = {24'h000000, `DMFC_FB_COUNT};
			8'h01:   next_rdata = {16'h0000, `DMFC_MAP_FIRST};
			8'h02:   next_rdata = {16'h0000, `DMFC_MAP_SECOND};
			8'h03:   next_rdata = {16'h0000, `DMFC_MAP_THIRD};
			default: next_err   = 1'b1;
			endcase
		end
		default: next_err = 1'b1;
		endcase
	end

	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			od_ack_o   <= 1'b0;
			od_err_o   <= 1'b0;
			od_rdata_o <= `DMFC_WORD_RESET;
			reboot_cmd <= `DMFC_WORD_RESET;
			reboot_dly <= `DMFC_WORD_RESET;
			boot_hw    <= `DMFC_WORD_RESET;
			submode    <= `DMFC_WORD_RESET;
			sel_first  <= `DMFC_SEL_RESET;
			sel_second <= `DMFC_SEL_RESET;
			sel_third  <= `DMFC_SEL_RESET;
		end else begin
			od_ack_o   <= od_req_i;
			od_err_o   <= od_req_i & next_err;
			od_rdata_o <= (od_req_i & ~od_wr_i & ~next_err) ? next_rdata : 32'h00000000;
			if (wr_ok) begin
				case (od_index_i)
				`DMFC_IDX_BOOT: begin
					if (od_sub_i == `DMFC_SUB_REBOOT_CMD)
						reboot_cmd <= od_wdata_i;
					if (od_sub_i == `DMFC_SUB_REBOOT_DLY)
						reboot_dly <= od_wdata_i;
					if (od_sub_i == `DMFC_SUB_BOOT_HW)
						boot_hw <= od_wdata_i;
				end
				`DMFC_IDX_SUBMODE:
					submode <= od_wdata_i & `DMFC_SM_USED_MASK;
				`DMFC_IDX_FB_SELECT: begin
					// stored at once, but only sampled at the next enable
					if (od_sub_i == 8'h01)
						sel_first <= od_wdata_i[7:0];
					if (od_sub_i == 8'h02)
						sel_second <= od_wdata_i[7:0];
					if (od_sub_i == 8'h03)
						sel_third <= od_wdata_i[7:0];
				end
				default: ;
				endcase
			end
		end
	end

	// reboot scheduler; a new magic write restarts the delay
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reboot_pend <= 1'b0;
			ms_left     <= 32'h00000000;
			tick_cnt    <= 32'h00000000;
			reboot_o    <= 1'b0;
		end else begin
			reboot_o <= 1'b0;
			if (wr_ok && od_index_i == `DMFC_IDX_BOOT && od_sub_i == `DMFC_SUB_REBOOT_CMD
				&& od_wdata_i == `DMFC_REBOOT_MAGIC) begin
				reboot_pend <= 1'b1;
				ms_left     <= reboot_dly;
				tick_cnt    <= 32'h00000000;
			end else if (reboot_pend) begin
				if (ms_left == 32'h00000000) begin
					reboot_pend <= 1'b0;
					reboot_o    <= 1'b1;
				end else if (ms_tick) begin
					tick_cnt <= 32'h00000000;
					ms_left  <= ms_left - 32'h00000001;
				end else begin
					tick_cnt <= tick_cnt + 32'h00000001;
				end
			end
		end
	end

	// index pin crosses in through two flops
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idx_meta <= 1'b0;
			idx_sync <= 1'b0;
		end else begin
			idx_meta <= enc_index_i;
			idx_sync <= idx_meta;
		end
	end

	// loop mode latches only outside operation enabled, selections on entry to it
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			op_en_q      <= 1'b0;
			loop_applied <= 1'b0;
			sel_applied  <= 24'h000000;
		end else begin
			op_en_q <= op_enabled_i;
			if (!op_enabled_i)
				loop_applied <= submode[`DMFC_SM_LOOP];
			if (op_rise)
				sel_applied <= {sel_third, sel_second, sel_first};
		end
	end

	// commutation sequence from switch-on to closed loop
	always @* begin
		next_state = state;
		case (state)
		ST_OPEN: begin
			if (op_rise && loop_applied) begin
				if (submode[`DMFC_SM_AUTO_ALIGN] || !enc_has_index_i)
					next_state = ST_ALIGN;
			end else if (op_enabled_i && loop_applied && idx_sync
				&& enc_has_index_i && !submode[`DMFC_SM_AUTO_ALIGN])
				next_state = ST_CLOSED;
		end
		ST_ALIGN: begin
			if (!op_enabled_i)
				next_state = ST_OPEN;
			else if (align_done_i)
				next_state = ST_CLOSED;
		end
		ST_CLOSED: begin
			if (!op_enabled_i || !loop_applied)
				next_state = ST_OPEN;
		end
		default: next_state = ST_OPEN;
		endcase
	end

	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i)
			state <= ST_OPEN;
		else
			state <= next_state;
	end

	dmfc_fb_search #(
		.NUM_FB (3)
	) u_search (
		.masks_i   (sel_applied),
		.pos_src_o (pos_sel),
		.vel_src_o (vel_sel),
		.com_src_o (com_sel)
	);

	// registered function outputs
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			windings_short_o <= 1'b1;
			closed_loop_o    <= 1'b0;
			align_active_o   <= 1'b0;
			speed_sim_o      <= 1'b0;
			brake_auto_o     <= 1'b0;
			cur_red_o        <= 1'b0;
			torque_only_o    <= 1'b0;
			vel_superimp_o   <= 1'b0;
			brushless_o      <= 1'b0;
			slow_mode_o      <= 1'b0;
			pos_src_o        <= 8'h01;
			vel_src_o        <= 8'h01;
			com_src_o        <= 8'h01;
		end else begin
			windings_short_o <= ~boot_hw[`DMFC_BOOT_NO_SHORT];
			closed_loop_o    <= (state == ST_CLOSED);
			align_active_o   <= (state == ST_ALIGN);
			speed_sim_o      <= submode[`DMFC_SM_SPEED_SIM];
			brake_auto_o     <= submode[`DMFC_SM_BRAKE];
			cur_red_o        <= submode[`DMFC_SM_CUR_RED] & (state != ST_CLOSED);
			torque_only_o    <= torque_mode_i & submode[`DMFC_SM_TORQUE];
			vel_superimp_o   <= torque_mode_i & ~submode[`DMFC_SM_TORQUE];
			brushless_o      <= submode[`DMFC_SM_BRUSHLESS];
			// slow speed is meaningless before the loop is closed
			slow_mode_o      <= submode[`DMFC_SM_SLOW] & (state == ST_CLOSED);
			pos_src_o        <= pos_sel;
			vel_src_o        <= vel_sel;
			com_src_o        <= loop_applied ? com_sel : 8'h01;
		end
	end
endmodule // dmfc_top
